// file: pkg/slcd_pkg.sv
// Functional notes
// - Setting driver enable (control bit 7) starts the waveform generator.
// - Driver enable clear: all plane outputs off, waveform clocks stopped.
// - Enabled: enabled frontplanes and selected backplanes output waveforms.
// - Waveform bit 6 (low power) changes only the request rate; plane waveforms do not depend on it.
// - Base clock is source clock divided by 16 times two to prescale.
// - Backplane count: 00 reserved, 01 two, 10 three, 11 four.
// - Shared pin is backplane 3 for 11 (default) and 00, frontplane 40 for 01 and 10.
// - Both control registers readable anytime; driver enable writable anytime.
// - Interrupt enable raises request per frame, or sub-frame in low power.
// - Wait gate bit 1 set stops the driver in wait mode.
// - Deep stop gate bit 0 set stops the driver in stop3.
// - Frontplane enable bits gate their pins only while driver enabled.
package slcd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SLCD_ADDR_DRV  = 8'h00;
  localparam logic [7:0] SLCD_ADDR_IPC  = 8'h04;
  localparam logic [7:0] SLCD_ADDR_FPLO = 8'h08;
  localparam logic [7:0] SLCD_ADDR_FPHI = 8'h0c;
  localparam logic [7:0] SLCD_ADDR_STAT = 8'h10;

  localparam int SLCD_DRV_EN_BIT   = 7;
  localparam int SLCD_LPW_BIT      = 6;
  localparam int SLCD_PRE_LSB      = 3;
  localparam int SLCD_DUTY_LSB     = 0;
  localparam int SLCD_IRQEN_BIT    = 7;
  localparam int SLCD_WAIT_BIT     = 1;
  localparam int SLCD_STOP_BIT     = 0;
  localparam int SLCD_ST_PEND_BIT  = 0;
  localparam int SLCD_ST_RUN_BIT   = 1;
  localparam int SLCD_ST_POL_BIT   = 2;
  localparam int SLCD_ST_PHASE_LSB = 4;

  localparam logic [7:0] SLCD_DRV_RESET = 8'h03;
  localparam logic [7:0] SLCD_IPC_RESET = 8'h00;
  localparam logic [7:0] SLCD_DRV_WMASK = 8'hfb;
  localparam logic [7:0] SLCD_IPC_WMASK = 8'h83;

  localparam logic [1:0] SLCD_DUTY_RSVD    = 2'h0;
  localparam logic [1:0] SLCD_DUTY_HALF    = 2'h1;
  localparam logic [1:0] SLCD_DUTY_THIRD   = 2'h2;
  localparam logic [1:0] SLCD_DUTY_QUARTER = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SLCD_SRC_HZ   = 32768;
  localparam int SLCD_BASE_DIV = 16;
  localparam int SLCD_PRE_MAX  = 7;

  localparam logic [2:0] SLCD_HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    SLCD_OFF  = 3'b001,
    SLCD_RUN  = 3'b010,
    SLCD_HOLD = 3'b100
  } slcd_state_t;

endpackage

// file: src/slcd_div.sv
`timescale 1ns/10ps
module slcd_div #(
  parameter int CNT_W = 11
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic       src_tick,
  input  wire logic [2:0] prescale,
  output logic            base_tick
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] last;
  logic             base_tick_reg;

  if (CNT_W < 4 + slcd_pkg::SLCD_PRE_MAX)
  begin : g_chk
    $error("slcd_div: CNT_W too small for largest prescale");
  end

  // ----------------------------------------------------------------
  // Divide source edges by 16 << prescale
  // ----------------------------------------------------------------
  assign last = CNT_W'((slcd_pkg::SLCD_BASE_DIV << prescale) - 1);

  // Held clear while stopped so a restart begins a whole base period
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg       <= '0;
      base_tick_reg <= 1'b0;
    end
    else if (!run)
    begin
      cnt_reg       <= '0;
      base_tick_reg <= 1'b0;
    end
    else if (src_tick)
    begin
      if (cnt_reg == last)
      begin
        cnt_reg       <= '0;
        base_tick_reg <= 1'b1;
      end
      else
      begin
        cnt_reg       <= cnt_reg + 1'b1;
        base_tick_reg <= 1'b0;
      end
    end
    else
    begin
      base_tick_reg <= 1'b0;
    end
  end

  assign base_tick = base_tick_reg;

  a_base_on_src: assert property (@(posedge hclk) disable iff (!hresetn)
    base_tick |-> $past(src_tick) && $past(run) && $past(cnt_reg) == $past(last))
    else $error("base tick without terminal source edge");

endmodule

// file: src/slcd_top.sv
`timescale 1ns/10ps
module slcd_top #(
  parameter int FP_COUNT = 40
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [7:0]          haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic                hready,
  input  wire logic [31:0]         hwdata,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                segment_source_clock,
  input  wire logic                wait_mode,
  input  wire logic                stop3_mode,
  output logic      [2:0]          backplane_outputs,
  output logic      [2:0]          backplane_oe,
  output logic      [FP_COUNT-1:0] frontplane_outputs,
  output logic      [FP_COUNT-1:0] frontplane_oe,
  output logic                     shared_plane_pin_out,
  output logic                     shared_plane_pin_oe,
  output logic                     frame_irq
);

  if (FP_COUNT < 33 || FP_COUNT > 40)
  begin : g_chk
    $error("slcd_top: FP_COUNT must lie in 33..40");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  slcd_pkg::slcd_state_t state_reg;
  slcd_pkg::slcd_state_t state_next;

  logic [7:0]          drv_reg;
  logic [7:0]          ipc_reg;
  logic [FP_COUNT:0]   fp_en_reg;
  logic                pend_reg;
  logic [1:0]          phase_reg;
  logic                pol_reg;
  logic                src_sync1_reg;
  logic                src_sync2_reg;
  logic                src_sync3_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_addr_reg;
  logic [31:0]         hrdata_reg;
  logic [31:0]         rdata_next;
  logic                hreadyout_reg;
  logic                hresp_reg;
  logic [2:0]          bp_out_reg;
  logic [2:0]          bp_oe_reg;
  logic [2:0]          bp_out_next;
  logic [2:0]          bp_oe_next;
  logic [FP_COUNT-1:0] fp_out_reg;
  logic [FP_COUNT-1:0] fp_oe_reg;
  logic                sh_out_reg;
  logic                sh_oe_reg;
  logic                irq_reg;

  logic       drv_en;
  logic       lpw;
  logic [2:0] prescale;
  logic [1:0] duty;
  logic       irqen;
  logic       gated;
  logic       running;
  logic       src_tick;
  logic       base_tick;
  logic [1:0] last_phase;
  logic       shared_is_bp;
  logic       wrap;
  logic       frame_evt;
  logic       xfer;
  logic       ack;

  // Number of backplanes scanned for a duty code
  function automatic logic [2:0] slcd_nbp(input logic [1:0] d);
    unique case (d)
      slcd_pkg::SLCD_DUTY_HALF:  slcd_nbp = 3'h2;
      slcd_pkg::SLCD_DUTY_THIRD: slcd_nbp = 3'h3;
      default:                   slcd_nbp = 3'h4;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  assign drv_en   = drv_reg[slcd_pkg::SLCD_DRV_EN_BIT];
  assign lpw      = drv_reg[slcd_pkg::SLCD_LPW_BIT];
  assign prescale = drv_reg[slcd_pkg::SLCD_PRE_LSB +: 3];
  assign duty     = drv_reg[slcd_pkg::SLCD_DUTY_LSB +: 2];
  assign irqen    = ipc_reg[slcd_pkg::SLCD_IRQEN_BIT];
  assign gated    = (wait_mode & ipc_reg[slcd_pkg::SLCD_WAIT_BIT])
                  | (stop3_mode & ipc_reg[slcd_pkg::SLCD_STOP_BIT]);
  assign running  = (state_reg == slcd_pkg::SLCD_RUN);

  assign last_phase   = 2'(slcd_nbp(duty) - 3'h1);
  assign shared_is_bp = (slcd_nbp(duty) == 3'h4);

  // ----------------------------------------------------------------
  // Source clock synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      src_sync1_reg <= 1'b0;
      src_sync2_reg <= 1'b0;
      src_sync3_reg <= 1'b0;
    end
    else
    begin
      src_sync1_reg <= segment_source_clock;
      src_sync2_reg <= src_sync1_reg;
      src_sync3_reg <= src_sync2_reg;
    end
  end

  assign src_tick = src_sync2_reg & ~src_sync3_reg;

  slcd_div #(
    .CNT_W (11)
  ) u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (running),
    .src_tick  (src_tick),
    .prescale  (prescale),
    .base_tick (base_tick)
  );

  // ----------------------------------------------------------------
  // Driver state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      slcd_pkg::SLCD_OFF:
        if (drv_en)
          state_next = gated ? slcd_pkg::SLCD_HOLD : slcd_pkg::SLCD_RUN;
      slcd_pkg::SLCD_RUN:
        if (!drv_en)
          state_next = slcd_pkg::SLCD_OFF;
        else if (gated)
          state_next = slcd_pkg::SLCD_HOLD;
      slcd_pkg::SLCD_HOLD:
        if (!drv_en)
          state_next = slcd_pkg::SLCD_OFF;
        else if (!gated)
          state_next = slcd_pkg::SLCD_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= slcd_pkg::SLCD_OFF;
    else
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Backplane scan
  // ----------------------------------------------------------------
  // Normal frame is both polarities; low power reports each half
  assign wrap      = running & base_tick & (phase_reg == last_phase);
  assign frame_evt = wrap & (lpw | pol_reg);

  // A hold keeps the scan position; only a disable restarts it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg <= 2'h0;
      pol_reg   <= 1'b0;
    end
    else if (state_reg == slcd_pkg::SLCD_OFF)
    begin
      phase_reg <= 2'h0;
      pol_reg   <= 1'b0;
    end
    else if (wrap)
    begin
      phase_reg <= 2'h0;
      pol_reg   <= ~pol_reg;
    end
    else if (running && base_tick)
    begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Plane outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      bp_oe_next[k]  = running & (3'(k) < slcd_nbp(duty));
      bp_out_next[k] = bp_oe_next[k] & ((phase_reg == 2'(k)) ^ pol_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bp_out_reg <= 3'h0;
      bp_oe_reg  <= 3'h0;
      fp_out_reg <= '0;
      fp_oe_reg  <= '0;
      sh_out_reg <= 1'b0;
      sh_oe_reg  <= 1'b0;
    end
    else
    begin
      bp_out_reg <= bp_out_next;
      bp_oe_reg  <= bp_oe_next;
      fp_oe_reg  <= {FP_COUNT{running}}
                  & fp_en_reg[FP_COUNT-1:0];
      fp_out_reg <= {FP_COUNT{running & ~pol_reg}}
                  & fp_en_reg[FP_COUNT-1:0];
      if (shared_is_bp)
      begin
        sh_oe_reg  <= running;
        sh_out_reg <= running & ((phase_reg == 2'h3) ^ pol_reg);
      end
      else
      begin
        sh_oe_reg  <= running & fp_en_reg[FP_COUNT];
        sh_out_reg <= running & fp_en_reg[FP_COUNT] & ~pol_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame request
  // ----------------------------------------------------------------
  assign ack = wr_pend_reg & (wr_addr_reg == slcd_pkg::SLCD_ADDR_STAT)
             & hwdata[slcd_pkg::SLCD_ST_PEND_BIT];

  // A new frame in the acknowledge cycle keeps the flag set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_reg <= 1'b0;
    else if (!drv_en)
      pend_reg <= 1'b0;
    else if (frame_evt && irqen)
      pend_reg <= 1'b1;
    else if (ack)
      pend_reg <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= pend_reg & irqen;
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign xfer = hsel & htrans[1] & hready;

  always_comb
  begin
    rdata_next = 32'h0;
    unique case (haddr)
      slcd_pkg::SLCD_ADDR_DRV:  rdata_next = {24'h0, drv_reg};
      slcd_pkg::SLCD_ADDR_IPC:  rdata_next = {24'h0, ipc_reg};
      slcd_pkg::SLCD_ADDR_FPLO: rdata_next = fp_en_reg[31:0];
      slcd_pkg::SLCD_ADDR_FPHI: rdata_next = 32'(fp_en_reg[FP_COUNT:32]);
      slcd_pkg::SLCD_ADDR_STAT:
      begin
        rdata_next[slcd_pkg::SLCD_ST_PEND_BIT]       = pend_reg;
        rdata_next[slcd_pkg::SLCD_ST_RUN_BIT]        = running;
        rdata_next[slcd_pkg::SLCD_ST_POL_BIT]        = pol_reg;
        rdata_next[slcd_pkg::SLCD_ST_PHASE_LSB +: 2] = phase_reg;
      end
      default:                  rdata_next = 32'h0;
    endcase
  end

  // Zero wait states: read data is captured at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= 8'h0;
      hrdata_reg    <= 32'h0;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
    else if (hready)
    begin
      wr_pend_reg <= xfer & hwrite & (hsize == slcd_pkg::SLCD_HSIZE_WORD);
      wr_addr_reg <= haddr;
      if (xfer && !hwrite)
        hrdata_reg <= rdata_next;
    end
  end

  // Prescale and duty take effect even while enabled; software avoids it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      drv_reg <= slcd_pkg::SLCD_DRV_RESET;
    else if (wr_pend_reg && wr_addr_reg == slcd_pkg::SLCD_ADDR_DRV)
      drv_reg <= hwdata[7:0] & slcd_pkg::SLCD_DRV_WMASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ipc_reg <= slcd_pkg::SLCD_IPC_RESET;
    else if (wr_pend_reg && wr_addr_reg == slcd_pkg::SLCD_ADDR_IPC)
      ipc_reg <= hwdata[7:0] & slcd_pkg::SLCD_IPC_WMASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fp_en_reg <= '0;
    else if (wr_pend_reg && wr_addr_reg == slcd_pkg::SLCD_ADDR_FPLO)
      fp_en_reg[31:0] <= hwdata;
    else if (wr_pend_reg && wr_addr_reg == slcd_pkg::SLCD_ADDR_FPHI)
      fp_en_reg[FP_COUNT:32] <= hwdata[FP_COUNT-32:0];
  end

  assign hrdata               = hrdata_reg;
  assign hreadyout            = hreadyout_reg;
  assign hresp                = hresp_reg;
  assign backplane_outputs    = bp_out_reg;
  assign backplane_oe         = bp_oe_reg;
  assign frontplane_outputs   = fp_out_reg;
  assign frontplane_oe        = fp_oe_reg;
  assign shared_plane_pin_out = sh_out_reg;
  assign shared_plane_pin_oe  = sh_oe_reg;
  assign frame_irq            = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_enable_runs: assert property (drv_en && !gated ##1 drv_en && !gated
    |=> running)
    else $error("enabled driver not running");

  a_off_quiet: assert property (!drv_en |-> ##2 (bp_oe_reg == 3'h0
    && fp_oe_reg == '0 && !sh_oe_reg && !base_tick))
    else $error("outputs active while disabled");

  a_fp_gate: assert property (fp_oe_reg[0]
    == $past(running && fp_en_reg[0]))
    else $error("frontplane gate wrong");

  a_lp_subframe: assert property (wrap && lpw && irqen && drv_en
    |=> pend_reg ##1 frame_irq)
    else $error("sub-frame request missed");

  a_half_duty: assert property (running && duty == slcd_pkg::SLCD_DUTY_HALF
    |=> !bp_oe_reg[2] && bp_oe_reg[1])
    else $error("two-backplane mode drives third");

  a_shared_role: assert property (sh_oe_reg == $past(running
    && (shared_is_bp || fp_en_reg[FP_COUNT])))
    else $error("shared pin role wrong");

  a_wait_gate: assert property (wait_mode && ipc_reg[1] |=> !running
    ##1 bp_oe_reg == 3'h0)
    else $error("driver runs in gated wait");

  a_stop_gate: assert property (stop3_mode && ipc_reg[0] |=> !running)
    else $error("driver runs in gated stop3");

  a_irq_masked: assert property (!irqen |=> !frame_irq)
    else $error("request raised while masked");

  a_pend_hold: assert property (pend_reg && drv_en && !ack |=> pend_reg)
    else $error("pending flag lost");

  a_read_ctl: assert property (xfer && !hwrite
    && haddr == slcd_pkg::SLCD_ADDR_DRV
    |=> hrdata[7:0] == $past(drv_reg))
    else $error("control read data wrong");

endmodule

// file: verif/slcd_glass.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Passive glass: times backplane steps, drives nothing back
// ----------------------------------------------------------------
module slcd_glass (
  input  wire logic        hclk,
  input  wire logic [2:0]  bp_level,
  input  wire logic [2:0]  bp_oe,
  output logic      [15:0] step_gap
);
  logic [15:0] cnt;
  logic [2:0]  last;

  // A floating plane carries no step, so only driven steps are timed
  always @(posedge hclk)
  begin
    last <= bp_level;
    if (bp_oe[0] && bp_level !== last)
    begin
      step_gap <= cnt;
      cnt      <= 16'h0001;
    end
    else
      cnt <= cnt + 16'h0001;
  end
endmodule

// file: verif/slcd_top_tb.sv
`timescale 1ns/10ps
module slcd_top_tb;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, bp_out, bp_oe;
  logic [31:0] hwdata, hrdata, hrd_s, q;
  logic        src, wait_mode, stop3_mode, sh_out, sh_oe, frame_irq, irq_l;
  logic [39:0] fp_out, fp_oe;
  logic [15:0] gap;
  logic [2:0]  src_div;
  int          n_errors, cmp_count, irq_cnt, irq_gap;

  assign hready = hreadyout;

  slcd_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .segment_source_clock(src),
    .wait_mode(wait_mode), .stop3_mode(stop3_mode),
    .backplane_outputs(bp_out), .backplane_oe(bp_oe),
    .frontplane_outputs(fp_out), .frontplane_oe(fp_oe),
    .shared_plane_pin_out(sh_out), .shared_plane_pin_oe(sh_oe),
    .frame_irq(frame_irq));

  slcd_glass glass_u (.hclk(hclk), .bp_level(bp_out), .bp_oe(bp_oe),
    .step_gap(gap));

  // ----------------------------------------------------------------
  // Clocks and monitors
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Source clock locked to hclk (period 8) so tick gaps are exact
  always @(posedge hclk)
  begin
    src_div <= src_div + 3'h1;
    if (src_div[1:0] == 2'h3)
      src <= ~src;
    irq_l <= frame_irq;
    if (frame_irq === 1'b1 && irq_l === 1'b0)
    begin
      irq_gap <= irq_cnt;
      irq_cnt <= 1;
    end
    else
      irq_cnt <= irq_cnt + 1;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [127:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is looked at just before the edge that samples it
  task automatic rdy;
    int n;
    n = 0;
    do
    begin
      @(negedge hclk);
      n++;
      if (n > 100)
      begin
        n_errors++;
        stop_test();
      end
    end
    while (hreadyout !== 1'b1);
    hrd_s = hrdata;
    @(posedge hclk);
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    hsize  <= slcd_pkg::SLCD_HSIZE_WORD;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    check("hresp", hresp, 1'b0);
    r = hrd_s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic drv(input logic [7:0] v);
    wr(slcd_pkg::SLCD_ADDR_DRV, {24'h0, v});
    repeat (3) @(posedge hclk);
  endtask

  task automatic wait_irq;
    int n;
    // A request just cleared still shows for a cycle; wait for a fresh one
    for (n = 0; n < 5000 && frame_irq !== 1'b0; n++)
      @(posedge hclk);
    while (n < 5000 && frame_irq !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= 5000)
    begin
      n_errors++;
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    {src, src_div, wait_mode, stop3_mode, irq_cnt, irq_gap} = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, slcd_pkg::SLCD_ADDR_DRV, 0, q);
    check("drv reset", q, 32'h03);
    ahb(1'b0, slcd_pkg::SLCD_ADDR_IPC, 0, q);
    check("ipc reset", q, 32'h00);
    ahb(1'b0, 8'h14, 0, q);
    check("unmapped", q, 32'h00);
    drv(8'h7f);
    ahb(1'b0, slcd_pkg::SLCD_ADDR_DRV, 0, q);
    check("drv rw", q, 32'h7b);
    wr(slcd_pkg::SLCD_ADDR_IPC, 32'hff);
    ahb(1'b0, slcd_pkg::SLCD_ADDR_IPC, 0, q);
    check("ipc rw", q, 32'h83);
    wr(slcd_pkg::SLCD_ADDR_IPC, 32'h00);
    wr(slcd_pkg::SLCD_ADDR_FPLO, 32'h5);
    drv(8'h03);
    check("fp off", {fp_oe, bp_oe, sh_oe}, 0);
    // Duty is changed only while the driver is off
    for (int d = 0; d < 4; d++)
    begin
      drv(8'(d));
      drv(8'h80 | 8'(d));
      check("bp oe", bp_oe, d == 1 ? 3'h3 : 3'h7);
      check("shared", sh_oe, d == 1 || d == 2 ? 1'b0 : 1'b1);
      check("fp oe", fp_oe, 40'h5);
      check("fp out", fp_out & ~40'h5, 0);
      drv(8'(d));
      check("all off", {fp_oe, bp_oe, sh_oe}, 0);
      check("pins low", {fp_out, bp_out, sh_out}, 0);
    end
    wr(slcd_pkg::SLCD_ADDR_FPHI, 32'h100);
    drv(8'h81);
    check("fp40", sh_oe, 1'b1);
    drv(8'h01);
    for (int p = 0; p < 3; p += 2)
    begin
      drv(8'(p << 3) | 8'h02);
      drv(8'h80 | 8'(p << 3) | 8'h02);
      repeat (4 * (128 << p)) @(posedge hclk);
      check("base tick", gap, 16'(128 << p));
      drv(8'(p << 3) | 8'h02);
    end
    wr(slcd_pkg::SLCD_ADDR_IPC, 32'h80);
    drv(8'h82);
    for (int lp = 0; lp < 2; lp++)
    begin
      drv(lp ? 8'hc2 : 8'h82);
      repeat (3)
      begin
        wait_irq();
        ahb(1'b0, slcd_pkg::SLCD_ADDR_STAT, 0, q);
        check("pending", q[0], 1'b1);
        wr(slcd_pkg::SLCD_ADDR_STAT, 32'h1);
      end
      check("irq gap", irq_gap, lp ? 384 : 768);
    end
    wait_irq();
    repeat (100) @(posedge hclk);
    check("irq held", frame_irq, 1'b1);
    drv(8'h42);
    check("irq off", frame_irq, 1'b0);
    wr(slcd_pkg::SLCD_ADDR_IPC, 32'h00);
    drv(8'hc2);
    repeat (1000) @(posedge hclk);
    ahb(1'b0, slcd_pkg::SLCD_ADDR_STAT, 0, q);
    check("no irq", {q[0], frame_irq}, 2'h0);
    // Source keeps running in stop3, as the external reference would
    wait_mode  <= 1'b1;
    stop3_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    check("gate clear", bp_oe, 3'h7);
    for (int g = 0; g < 2; g++)
    begin
      wait_mode  <= g == 0;
      stop3_mode <= g == 1;
      wr(slcd_pkg::SLCD_ADDR_IPC, g ? 32'h1 : 32'h2);
      repeat (4) @(posedge hclk);
      check("gated", {bp_oe, sh_oe, fp_oe}, 0);
      wr(slcd_pkg::SLCD_ADDR_IPC, 32'h0);
      repeat (4) @(posedge hclk);
      check("ungated", bp_oe, 3'h7);
    end
    stop_test();
  end
endmodule
